// *** rtl/tos_map.svh ***
/*
 * Address map, field positions, reset values and timing counts of the
 * machine thermal stage. Assumes inclusion by bare name from the rtl files.
 */
`ifndef TOS_MAP_SVH
`define TOS_MAP_SVH

`define TOS_OFF_CTRL 8'h00
`define TOS_OFF_ALARM1_LVL 8'h04
`define TOS_OFF_ALARM2_LVL 8'h08
`define TOS_OFF_INHIBIT_LVL 8'h0c
`define TOS_OFF_TRIP_LVL 8'h10
`define TOS_OFF_TRIP_DELAY 8'h14
`define TOS_OFF_STATUS 8'h18
`define TOS_OFF_IRQ_STATUS 8'h1c
`define TOS_OFF_IRQ_MASK 8'h20
`define TOS_OFF_CNT_TRIP 8'h24
`define TOS_OFF_CNT_ALARM1 8'h28
`define TOS_OFF_CNT_ALARM2 8'h2c
`define TOS_OFF_CNT_INHIBIT 8'h30
`define TOS_OFF_CNT_BLOCKED 8'h34

`define TOS_CTRL_A1_EN 0
`define TOS_CTRL_A2_EN 1
`define TOS_CTRL_INH_EN 2
`define TOS_CTRL_CNT_CLR 3

`define TOS_EV_TRIP 0
`define TOS_EV_ALARM1 1
`define TOS_EV_ALARM2 2
`define TOS_EV_INHIBIT 3
`define TOS_EV_BLOCKED 4
`define TOS_EV_N 5

`define TOS_LVL_W 12
`define TOS_DLY_W 20
`define TOS_CNT_W 16
`define TOS_STEP_W 17
`define TOS_FAC_W 16
`define TOS_CUR_W 16

`define TOS_RST_CTRL 4'h0
`define TOS_RST_ALARM1_LVL 12'h190
`define TOS_RST_ALARM2_LVL 12'h190
`define TOS_RST_INHIBIT_LVL 12'h320
`define TOS_RST_TRIP_LVL 12'h3e8
`define TOS_RST_TRIP_DELAY 20'h00000
`define TOS_FACTOR_ONE 16'h0064
`define TOS_CUR_LIGHT 16'h000a
`define TOS_CUR_HIGH 16'h07d0

`define TOS_CLK_PERIOD_NS 40
`define TOS_TRIP_STEP_NS 5000000
`define TOS_TRIP_STEP_CYCLES ((`TOS_TRIP_STEP_NS + `TOS_CLK_PERIOD_NS - 1) / `TOS_CLK_PERIOD_NS)

`endif

// *** rtl/tos_pkg.sv ***
/*
 * Types of the machine thermal stage: operating condition, load status and
 * trip sequencer states. Assumes nothing of its surroundings.
 */
package tos_pkg;
	typedef enum logic [2:0] {
		COND_NORMAL = 3'h0,
		COND_ALARM1 = 3'h1,
		COND_ALARM2 = 3'h2,
		COND_INHIBIT = 3'h3,
		COND_TRIP = 3'h4,
		COND_BLOCKED = 3'h5
	} tos_cond_t;

	typedef enum logic [1:0] {
		LOAD_LIGHT = 2'h0,
		LOAD_NORMAL = 2'h1,
		LOAD_OVER = 2'h2,
		LOAD_HIGH = 2'h3
	} tos_load_t;

	typedef enum logic [1:0] {
		TRIP_IDLE = 2'h0,
		TRIP_TIMING = 2'h1,
		TRIP_ACTIVE = 2'h2,
		TRIP_BLOCKED = 2'h3
	} tos_trip_state_t;
endpackage

// *** rtl/tos_threshold.sv ***
/*
 * Registered threshold comparator with enable.
 * Assumes capacity and level share the same 0.1 percent scale.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tos_map.svh"

module tos_threshold (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [`TOS_LVL_W-1:0] capacity,
	input wire logic [`TOS_LVL_W-1:0] level,
	output logic hit
);
	logic hit_d;

	always_comb begin
		hit_d = enable && (capacity >= level); // RULE1 RULE19
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hit <= 1'b0;
		end else begin
			hit <= hit_d;
		end
	end

	chk_level_reached: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
		enable && (capacity >= level) |=> hit) else $error("threshold reached but output low");
	chk_level_fallen: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
		(capacity < level) |=> !hit) else $error("output high below threshold");
endmodule // tos_threshold

`default_nettype wire

// *** rtl/tos_event_counter.sv ***
/*
 * Saturating cumulative event counter with synchronous clear.
 * Assumes incr is a one-cycle pulse per occurrence.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tos_map.svh"

module tos_event_counter (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic incr,
	output logic [`TOS_CNT_W-1:0] count
);
	logic [`TOS_CNT_W-1:0] count_d;

	always_comb begin
		count_d = count;
		if (clear) begin
			count_d = '0;
		end else if (incr && (count != '1)) begin
			count_d = count + 1'b1; // RULE18
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count <= '0;
		end else begin
			count <= count_d;
		end
	end

	chk_count_step: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
		incr && !clear && (count != '1) |=> count == $past(count) + 1'b1) else $error("counter missed an event");
endmodule // tos_event_counter

`default_nettype wire

// *** rtl/tos_machine_thermal_stage.sv ***
/*
 * Output and status stage of the machine thermal overload function: threshold
 * outputs, delayed trip with blocking, condition and load status, setting
 * fault substitution, event counters and an Avalon-MM register slave.
 * Assumes thermal capacity, currents, blocking and cycle strobe come from
 * logic on clk; capacity and levels in 0.1 percent, currents in 0.001 x In.
 */
// The Avalon-MM register port and the placing of the registers were left to the implementer.
// Behaviour
// RULE1 - Outputs follow thermal capacity versus thresholds only.
// RULE2 - Alarm 1 enableable, off by default, 40 percent.
// RULE3 - Alarm 2 independent enable and level, 40 percent.
// RULE4 - Restart inhibit enableable, default level 80 percent.
// RULE5 - Trip always enabled, default level 100 percent.
// RULE6 - Trip delayed in 5 ms steps, zero adds none.
// RULE7 - Blocking input sampled at each cycle start.
// RULE8 - Pick-up unblocked gives start and timing.
// RULE9 - Pick-up while blocked gives blocked, nothing more.
// RULE10 - Blocking after start clears start, releases timing.
// RULE11 - Blocker asserts 5 ms before delay expires.
// RULE12 - Report condition code; normal drives nothing.
// RULE13 - Report light, normal, overloading, high overload.
// RULE14 - Bad service factor uses 1.0, flags fault.
// RULE15 - Bad ambient settings use 1.0, flag fault.
// RULE16 - Bad nominal current uses 1.0, flags fault.
// RULE17 - Inconsistent ambient coefficient flagged while present.
// RULE18 - Resettable counters of trip, alarms, inhibit, blocked.
// RULE19 - Output on at or above level, off below.
`timescale 1ns/100ps
`default_nettype none
`include "tos_map.svh"

module tos_machine_thermal_stage #(
	parameter int unsigned STEP_CYCLES = `TOS_TRIP_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic [`TOS_LVL_W-1:0] thermalCapacity,
	input wire logic [`TOS_CUR_W-1:0] measCurrent,
	input wire logic [`TOS_CUR_W-1:0] pickupCurrent,
	input wire logic cycleStart,
	input wire logic blockIn,
	input wire logic [`TOS_FAC_W-1:0] serviceFactorSet,
	input wire logic serviceFactorBad,
	input wire logic [`TOS_FAC_W-1:0] ambientFactorSet,
	input wire logic ambientBad,
	input wire logic [`TOS_FAC_W-1:0] nominalFactorSet,
	input wire logic nominalBad,
	input wire logic ambientCoefBad,
	output logic [`TOS_FAC_W-1:0] serviceFactorUsed,
	output logic [`TOS_FAC_W-1:0] ambientFactorUsed,
	output logic [`TOS_FAC_W-1:0] nominalFactorUsed,
	output logic alarm1Out,
	output logic alarm2Out,
	output logic inhibitOut,
	output logic tripOut,
	output logic startOut,
	output logic blockedOut,
	output tos_pkg::tos_cond_t condition,
	output tos_pkg::tos_load_t loadStatus,
	output logic [3:0] settingFault,
	output logic irq
);
	// Applies byte enables of a bus write to the old register value.
	function automatic logic [31:0] wrMerge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = data[8*i +: 8];
			end
		end
		return r;
	endfunction

	logic ack_q, ack_d;
	logic [31:0] readdata_d;
	logic [3:0] ctrl_q, ctrl_d;
	logic [`TOS_LVL_W-1:0] a1Lvl_q, a1Lvl_d, a2Lvl_q, a2Lvl_d, inhLvl_q, inhLvl_d, tripLvl_q, tripLvl_d;
	logic [`TOS_DLY_W-1:0] tripDelay_q, tripDelay_d;
	logic [`TOS_EV_N-1:0] irqStatus_q, irqStatus_d, irqMask_q, irqMask_d;
	logic [`TOS_EV_N-1:0] prevOut_q, prevOut_d, events;
	logic wrDone, rdDone, cntClear, pickup;
	logic blkSample_q, blkSample_d;
	tos_pkg::tos_trip_state_t state_q, state_d;
	logic [`TOS_STEP_W-1:0] stepCnt_q, stepCnt_d;
	logic [`TOS_DLY_W-1:0] delayCnt_q, delayCnt_d;
	tos_pkg::tos_cond_t condition_d;
	tos_pkg::tos_load_t loadStatus_d;
	logic [3:0] settingFault_d;
	logic [`TOS_FAC_W-1:0] sfUsed_d, ambUsed_d, nomUsed_d;
	logic [`TOS_EV_N-1:0][`TOS_CNT_W-1:0] counts;
	logic [31:0] statusWord, rdMux;

	// Bus slave: one wait state, the access completes on the second edge.
	assign waitrequest = (read || write) && !ack_q;
	assign wrDone = write && ack_q;
	assign rdDone = read && ack_q;
	assign cntClear = wrDone && (address == `TOS_OFF_CTRL) && byteenable[0] && writedata[`TOS_CTRL_CNT_CLR];

	always_comb begin
		rdMux = 32'h0000_0000;
		unique case (address)
			`TOS_OFF_CTRL: rdMux[3:0] = ctrl_q;
			`TOS_OFF_ALARM1_LVL: rdMux[`TOS_LVL_W-1:0] = a1Lvl_q;
			`TOS_OFF_ALARM2_LVL: rdMux[`TOS_LVL_W-1:0] = a2Lvl_q;
			`TOS_OFF_INHIBIT_LVL: rdMux[`TOS_LVL_W-1:0] = inhLvl_q;
			`TOS_OFF_TRIP_LVL: rdMux[`TOS_LVL_W-1:0] = tripLvl_q;
			`TOS_OFF_TRIP_DELAY: rdMux[`TOS_DLY_W-1:0] = tripDelay_q;
			`TOS_OFF_STATUS: rdMux = statusWord;
			`TOS_OFF_IRQ_STATUS: rdMux[`TOS_EV_N-1:0] = irqStatus_q;
			`TOS_OFF_IRQ_MASK: rdMux[`TOS_EV_N-1:0] = irqMask_q;
			`TOS_OFF_CNT_TRIP: rdMux[`TOS_CNT_W-1:0] = counts[`TOS_EV_TRIP];
			`TOS_OFF_CNT_ALARM1: rdMux[`TOS_CNT_W-1:0] = counts[`TOS_EV_ALARM1];
			`TOS_OFF_CNT_ALARM2: rdMux[`TOS_CNT_W-1:0] = counts[`TOS_EV_ALARM2];
			`TOS_OFF_CNT_INHIBIT: rdMux[`TOS_CNT_W-1:0] = counts[`TOS_EV_INHIBIT];
			`TOS_OFF_CNT_BLOCKED: rdMux[`TOS_CNT_W-1:0] = counts[`TOS_EV_BLOCKED];
			default: rdMux = 32'h0000_0000;
		endcase
	end

	always_comb begin
		ack_d = (read || write) && !ack_q;
		readdata_d = readdata;
		if (read && !ack_q) begin
			readdata_d = rdMux;
		end
		ctrl_d = ctrl_q;
		a1Lvl_d = a1Lvl_q;
		a2Lvl_d = a2Lvl_q;
		inhLvl_d = inhLvl_q;
		tripLvl_d = tripLvl_q;
		tripDelay_d = tripDelay_q;
		irqMask_d = irqMask_q;
		if (wrDone) begin
			unique case (address)
				`TOS_OFF_CTRL: ctrl_d = 4'(wrMerge({28'h0, ctrl_q}, writedata, byteenable)) & 4'h7;
				`TOS_OFF_ALARM1_LVL: a1Lvl_d = `TOS_LVL_W'(wrMerge(32'(a1Lvl_q), writedata, byteenable)); // RULE2
				`TOS_OFF_ALARM2_LVL: a2Lvl_d = `TOS_LVL_W'(wrMerge(32'(a2Lvl_q), writedata, byteenable)); // RULE3
				`TOS_OFF_INHIBIT_LVL: inhLvl_d = `TOS_LVL_W'(wrMerge(32'(inhLvl_q), writedata, byteenable)); // RULE4
				`TOS_OFF_TRIP_LVL: tripLvl_d = `TOS_LVL_W'(wrMerge(32'(tripLvl_q), writedata, byteenable)); // RULE5
				`TOS_OFF_TRIP_DELAY: tripDelay_d = `TOS_DLY_W'(wrMerge(32'(tripDelay_q), writedata, byteenable)); // RULE6
				`TOS_OFF_IRQ_MASK: irqMask_d = `TOS_EV_N'(wrMerge(32'(irqMask_q), writedata, byteenable));
				default: ctrl_d = ctrl_q;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			readdata <= 32'h0000_0000;
			ctrl_q <= `TOS_RST_CTRL;
			a1Lvl_q <= `TOS_RST_ALARM1_LVL;
			a2Lvl_q <= `TOS_RST_ALARM2_LVL;
			inhLvl_q <= `TOS_RST_INHIBIT_LVL;
			tripLvl_q <= `TOS_RST_TRIP_LVL;
			tripDelay_q <= `TOS_RST_TRIP_DELAY;
			irqMask_q <= '0;
		end else begin
			ack_q <= ack_d;
			readdata <= readdata_d;
			ctrl_q <= ctrl_d;
			a1Lvl_q <= a1Lvl_d;
			a2Lvl_q <= a2Lvl_d;
			inhLvl_q <= inhLvl_d;
			tripLvl_q <= tripLvl_d;
			tripDelay_q <= tripDelay_d;
			irqMask_q <= irqMask_d;
		end
	end

	// Threshold outputs; a disabled output stays low along with its I/O.
	tos_threshold uAlarm1 (
		.clk(clk), .rst_n(rst_n), .enable(ctrl_q[`TOS_CTRL_A1_EN]), // RULE2
		.capacity(thermalCapacity), .level(a1Lvl_q), .hit(alarm1Out)
	);
	tos_threshold uAlarm2 (
		.clk(clk), .rst_n(rst_n), .enable(ctrl_q[`TOS_CTRL_A2_EN]), // RULE3
		.capacity(thermalCapacity), .level(a2Lvl_q), .hit(alarm2Out)
	);
	tos_threshold uInhibit (
		.clk(clk), .rst_n(rst_n), .enable(ctrl_q[`TOS_CTRL_INH_EN]), // RULE4
		.capacity(thermalCapacity), .level(inhLvl_q), .hit(inhibitOut)
	);
	tos_threshold uPickup (
		.clk(clk), .rst_n(rst_n), .enable(1'b1), // RULE5
		.capacity(thermalCapacity), .level(tripLvl_q), .hit(pickup)
	);

	// Trip sequencer: blocking is the value caught at the last cycle start.
	always_comb begin
		blkSample_d = cycleStart ? blockIn : blkSample_q; // RULE7
		state_d = state_q;
		stepCnt_d = '0;
		delayCnt_d = '0;
		unique case (state_q)
			tos_pkg::TRIP_IDLE: begin
				if (pickup && blkSample_q) begin
					state_d = tos_pkg::TRIP_BLOCKED; // RULE9
				end else if (pickup) begin
					state_d = (tripDelay_q == '0) ? tos_pkg::TRIP_ACTIVE : tos_pkg::TRIP_TIMING; // RULE6 RULE8
				end
			end
			tos_pkg::TRIP_TIMING: begin
				if (!pickup) begin
					state_d = tos_pkg::TRIP_IDLE;
				end else if (blkSample_q) begin
					state_d = tos_pkg::TRIP_BLOCKED; // RULE10 RULE11
				end else if (delayCnt_q >= tripDelay_q) begin
					state_d = tos_pkg::TRIP_ACTIVE;
				end else if (stepCnt_q == `TOS_STEP_W'(STEP_CYCLES - 1)) begin
					delayCnt_d = delayCnt_q + 1'b1; // RULE6
				end else begin
					stepCnt_d = stepCnt_q + 1'b1;
					delayCnt_d = delayCnt_q;
				end
			end
			tos_pkg::TRIP_ACTIVE: begin
				if (!pickup) begin
					state_d = tos_pkg::TRIP_IDLE;
				end else if (blkSample_q) begin
					state_d = tos_pkg::TRIP_BLOCKED; // RULE10
				end
			end
			tos_pkg::TRIP_BLOCKED: begin
				if (!pickup || !blkSample_q) begin
					state_d = tos_pkg::TRIP_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			blkSample_q <= 1'b0;
			state_q <= tos_pkg::TRIP_IDLE;
			stepCnt_q <= '0;
			delayCnt_q <= '0;
		end else begin
			blkSample_q <= blkSample_d;
			state_q <= state_d;
			stepCnt_q <= stepCnt_d;
			delayCnt_q <= delayCnt_d;
		end
	end

	assign tripOut = (state_q == tos_pkg::TRIP_ACTIVE);
	assign startOut = (state_q == tos_pkg::TRIP_TIMING) || (state_q == tos_pkg::TRIP_ACTIVE); // RULE8
	assign blockedOut = (state_q == tos_pkg::TRIP_BLOCKED); // RULE9

	// Status, load classification and setting-fault substitution.
	always_comb begin
		if (blockedOut) begin
			condition_d = tos_pkg::COND_BLOCKED; // RULE12
		end else if (tripOut) begin
			condition_d = tos_pkg::COND_TRIP;
		end else if (inhibitOut) begin
			condition_d = tos_pkg::COND_INHIBIT;
		end else if (alarm2Out) begin
			condition_d = tos_pkg::COND_ALARM2;
		end else if (alarm1Out) begin
			condition_d = tos_pkg::COND_ALARM1;
		end else begin
			condition_d = tos_pkg::COND_NORMAL;
		end
		if (measCurrent < `TOS_CUR_LIGHT) begin
			loadStatus_d = tos_pkg::LOAD_LIGHT; // RULE13
		end else if (measCurrent > `TOS_CUR_HIGH) begin
			loadStatus_d = tos_pkg::LOAD_HIGH;
		end else if (measCurrent > pickupCurrent) begin
			loadStatus_d = tos_pkg::LOAD_OVER;
		end else begin
			loadStatus_d = tos_pkg::LOAD_NORMAL;
		end
		sfUsed_d = serviceFactorBad ? `TOS_FACTOR_ONE : serviceFactorSet; // RULE14
		ambUsed_d = ambientBad ? `TOS_FACTOR_ONE : ambientFactorSet; // RULE15
		nomUsed_d = nominalBad ? `TOS_FACTOR_ONE : nominalFactorSet; // RULE16
		settingFault_d = {ambientCoefBad, nominalBad, ambientBad, serviceFactorBad}; // RULE14 RULE15 RULE16 RULE17
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			condition <= tos_pkg::COND_NORMAL;
			loadStatus <= tos_pkg::LOAD_LIGHT;
			serviceFactorUsed <= `TOS_FACTOR_ONE;
			ambientFactorUsed <= `TOS_FACTOR_ONE;
			nominalFactorUsed <= `TOS_FACTOR_ONE;
			settingFault <= 4'h0;
		end else begin
			condition <= condition_d;
			loadStatus <= loadStatus_d;
			serviceFactorUsed <= sfUsed_d;
			ambientFactorUsed <= ambUsed_d;
			nominalFactorUsed <= nomUsed_d;
			settingFault <= settingFault_d;
		end
	end

	assign statusWord = {16'h0000, blkSample_q, settingFault, blockedOut, startOut, tripOut, inhibitOut,
		alarm2Out, alarm1Out, loadStatus, condition};

	// Rising edges of the trip, alarm 1, alarm 2, inhibit and blocked outputs are the counted and interrupting events.
	always_comb begin
		prevOut_d = {blockedOut, inhibitOut, alarm2Out, alarm1Out, tripOut};
		events = prevOut_d & ~prevOut_q;
		irqStatus_d = irqStatus_q;
		if (rdDone && (address == `TOS_OFF_IRQ_STATUS)) begin
			irqStatus_d = irqStatus_q & ~readdata[`TOS_EV_N-1:0];
		end
		irqStatus_d = irqStatus_d | events;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prevOut_q <= '0;
			irqStatus_q <= '0;
		end else begin
			prevOut_q <= prevOut_d;
			irqStatus_q <= irqStatus_d;
		end
	end

	assign irq = |(irqStatus_q & irqMask_q);

	for (genvar i = 0; i < `TOS_EV_N; i++) begin : gCount
		tos_event_counter uCnt (
			.clk(clk), .rst_n(rst_n), .clear(cntClear), .incr(events[i]), .count(counts[i]) // RULE18
		);
	end

	chk_alarm1_disabled: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
		!ctrl_q[`TOS_CTRL_A1_EN] |=> !alarm1Out) else $error("alarm 1 driven while disabled");
	chk_alarm2_disabled: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
		!ctrl_q[`TOS_CTRL_A2_EN] |=> !alarm2Out) else $error("alarm 2 driven while disabled");
	chk_inhibit_level: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
		ctrl_q[`TOS_CTRL_INH_EN] && (thermalCapacity >= inhLvl_q) |=> inhibitOut) else $error("inhibit missed");
	chk_trip_nodelay: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
		(state_q == tos_pkg::TRIP_IDLE) && pickup && !blkSample_q && (tripDelay_q == '0) |=> tripOut)
		else $error("zero delay trip late");
	chk_block_sample: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
		cycleStart |=> blkSample_q == $past(blockIn)) else $error("blocking not sampled at cycle start");
	chk_blocked_nostart: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
		(state_q == tos_pkg::TRIP_IDLE) && pickup && blkSample_q |=> blockedOut && !startOut && !tripOut)
		else $error("blocked pick-up went on");
	chk_block_clears: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
		startOut && blkSample_q |=> !startOut) else $error("start kept under blocking");
	chk_sf_substitute: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
		serviceFactorBad |=> (serviceFactorUsed == `TOS_FACTOR_ONE) && settingFault[0])
		else $error("service factor not substituted");
	chk_normal_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
		!alarm1Out && !alarm2Out && !inhibitOut && !tripOut && !blockedOut |=> condition == tos_pkg::COND_NORMAL)
		else $error("condition not normal while quiet");
	chk_bus_wait: assert property (@(posedge clk) disable iff (!rst_n)
		(read || write) && waitrequest |=> !waitrequest) else $error("waitrequest held too long");
endmodule // tos_machine_thermal_stage

`default_nettype wire

// *** sim/tos_block_source.sv ***
/*
 * Blocking matrix model: program cycle strobe and a blocking line.
 * Assumes blockReq comes from the bench on the rising edge of clk.
 */
`timescale 1ns/100ps
`default_nettype none

module tos_block_source #(
	parameter int unsigned PERIOD = 4,
	parameter int unsigned LAG = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic blockReq,
	output logic cycleStart,
	output logic blockIn
);
	logic [7:0] cycleCnt_q, cycleCnt_d;
	logic [7:0] blockPipe_q, blockPipe_d;

	always_comb begin
		cycleCnt_d = (cycleCnt_q == 8'(PERIOD - 1)) ? 8'h00 : cycleCnt_q + 8'h01;
		blockPipe_d = {blockPipe_q[6:0], blockReq};
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cycleCnt_q <= 8'h00;
			blockPipe_q <= 8'h00;
		end else begin
			cycleCnt_q <= cycleCnt_d;
			blockPipe_q <= blockPipe_d;
		end
	end

	assign cycleStart = rst_n && (cycleCnt_q == 8'h00);
	// A larger lag models a slow matrix; it must still land well ahead of the delay end.
	assign blockIn = blockPipe_q[LAG-1];
endmodule // tos_block_source

`default_nettype wire

// *** sim/tb_thermal_overload_output_stage.sv ***
/*
 * Self-checking testbench of the machine thermal stage with a blocking model.
 * Assumes the stage, its package and the blocking model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tos_map.svh"

module tb_thermal_overload_output_stage;
	localparam int STEP = 4;
	localparam int DLY = 3;
	logic clk, rst_n, read, write, cycleStart, blockIn, blockReq, waitrequest, irq;
	logic serviceFactorBad, ambientBad, nominalBad, ambientCoefBad;
	logic alarm1Out, alarm2Out, inhibitOut, tripOut, startOut, blockedOut;
	logic [7:0] address;
	logic [31:0] writedata, readdata, q;
	logic [3:0] byteenable, settingFault;
	logic [11:0] thermalCapacity;
	logic [15:0] measCurrent, pickupCurrent, serviceFactorSet, ambientFactorSet, nominalFactorSet;
	logic [15:0] serviceFactorUsed, ambientFactorUsed, nominalFactorUsed;
	tos_pkg::tos_cond_t condition;
	tos_pkg::tos_load_t loadStatus;
	int fail_count, checks_done, cycles;

	tos_block_source #(.PERIOD(4), .LAG(1)) blocker (.clk, .rst_n, .blockReq, .cycleStart, .blockIn);

	tos_machine_thermal_stage #(.STEP_CYCLES(STEP)) dut (
		.clk, .rst_n, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
		.thermalCapacity, .measCurrent, .pickupCurrent, .cycleStart, .blockIn,
		.serviceFactorSet, .serviceFactorBad, .ambientFactorSet, .ambientBad,
		.nominalFactorSet, .nominalBad, .ambientCoefBad,
		.serviceFactorUsed, .ambientFactorUsed, .nominalFactorUsed,
		.alarm1Out, .alarm2Out, .inhibitOut, .tripOut, .startOut, .blockedOut,
		.condition, .loadStatus, .settingFault, .irq
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			stop_test();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Holds the request until waitrequest is sampled low at a rising edge; only the run timeout ends a wait.
	task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		read <= rd;
		write <= ~rd;
		writedata <= d;
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic setCap(input logic [11:0] c);
		@(posedge clk);
		thermalCapacity <= c;
	endtask

	task automatic testDefaults();
		logic [7:0] offs[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h40};
		logic [31:0] vals[7] = '{32'h0, 32'h190, 32'h190, 32'h320, 32'h3e8, 32'h0, 32'h0};
		bus(1'b0, 8'h40, 32'hffffffff);
		foreach (offs[i]) begin
			bus(1'b1, offs[i], 32'h0);
			chk("reset register", q, vals[i]);
		end
		chk("irq idle", irq, 1'b0);
	endtask

	task automatic testAlarms();
		int caps[6] = '{399, 400, 499, 500, 800, 0};
		setCap(12'h1f4);
		tick(3);
		chk("alarm1 disabled", alarm1Out, 1'b0);
		chk("cond disabled", condition, 32'h0);
		setCap(12'h000);
		bus(1'b0, `TOS_OFF_ALARM2_LVL, 32'h1f4);
		bus(1'b0, `TOS_OFF_CTRL, 32'h7);
		foreach (caps[i]) begin
			setCap(caps[i][11:0]);
			tick(3);
			chk("alarm1", alarm1Out, caps[i] >= 400);
			chk("alarm2", alarm2Out, caps[i] >= 500);
			chk("inhibit", inhibitOut, caps[i] >= 800);
			chk("cond", condition, caps[i] >= 800 ? 3 : caps[i] >= 500 ? 2 : caps[i] >= 400 ? 1 : 0);
		end
		bus(1'b1, `TOS_OFF_CNT_ALARM1, 32'h0);
		chk("alarm1 count", q, 32'h1);
	endtask

	task automatic testTrip();
		bus(1'b0, `TOS_OFF_IRQ_MASK, 32'h1);
		bus(1'b1, `TOS_OFF_IRQ_STATUS, 32'h0);
		setCap(12'h3e8);
		tick(4);
		chk("trip", tripOut, 1'b1);
		chk("start", startOut, 1'b1);
		chk("cond trip", condition, 32'h4);
		chk("irq set", irq, 1'b1);
		bus(1'b1, `TOS_OFF_IRQ_STATUS, 32'h0);
		chk("irq trip bit", q[0], 1'b1);
		tick(1);
		chk("irq cleared", irq, 1'b0);
		setCap(12'h3e7);
		tick(3);
		chk("trip below level", tripOut, 1'b0);
		bus(1'b1, `TOS_OFF_CNT_TRIP, 32'h0);
		chk("trip count", q, 32'h1);
	endtask

	task automatic testDelay();
		int n;
		bus(1'b0, `TOS_OFF_TRIP_DELAY, DLY);
		setCap(12'h3e8);
		tick(4);
		chk("start timing", startOut, 1'b1);
		chk("no early trip", tripOut, 1'b0);
		n = 4;
		while (tripOut !== 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		chk("delay window", n >= DLY * STEP && n <= DLY * STEP + DLY + 6, 1'b1);
		setCap(12'h000);
		tick(3);
		chk("trip released", tripOut | startOut, 1'b0);
	endtask

	task automatic testBlock();
		int n;
		@(posedge clk);
		blockReq <= 1'b1;
		tick(10);
		setCap(12'h3e8);
		tick(4);
		chk("blocked", blockedOut, 1'b1);
		chk("no start", startOut | tripOut, 1'b0);
		chk("cond blocked", condition, 32'h5);
		@(posedge clk);
		blockReq <= 1'b0;
		n = 0;
		while (startOut !== 1'b1 && n < 30) begin
			tick(1);
			n++;
		end
		chk("start after unblock", startOut, 1'b1);
		@(posedge clk);
		blockReq <= 1'b1;
		tick(7);
		chk("start cleared", startOut, 1'b0);
		chk("no trip", tripOut, 1'b0);
		chk("blocked again", blockedOut, 1'b1);
		setCap(12'h000);
		blockReq <= 1'b0;
		tick(10);
		bus(1'b1, `TOS_OFF_CNT_BLOCKED, 32'h0);
		chk("blocked count", q, 32'h2);
		bus(1'b0, `TOS_OFF_CTRL, 32'hf);
		bus(1'b1, `TOS_OFF_CNT_TRIP, 32'h0);
		chk("count cleared", q, 32'h0);
		bus(1'b1, `TOS_OFF_CTRL, 32'h0);
		chk("ctrl readback", q, 32'h7);
	endtask

	task automatic testLoad();
		int cur[6] = '{9, 10, 1100, 1101, 2000, 2001};
		int exp[6] = '{0, 1, 1, 2, 2, 3};
		foreach (cur[i]) begin
			@(posedge clk);
			measCurrent <= cur[i][15:0];
			tick(3);
			chk("load status", loadStatus, exp[i]);
		end
	endtask

	task automatic testFaults();
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			{ambientCoefBad, nominalBad, ambientBad, serviceFactorBad} <= (i < 4) ? 4'h1 << i : 4'h0;
			tick(3);
			chk("fault flags", settingFault, (i < 4) ? 32'h1 << i : 32'h0);
			chk("sf used", serviceFactorUsed, i == 0 ? 16'h0064 : 16'h0078);
			chk("amb used", ambientFactorUsed, i == 1 ? 16'h0064 : 16'h0082);
			chk("nom used", nominalFactorUsed, i == 2 ? 16'h0064 : 16'h008c);
		end
	endtask

	initial begin
		{rst_n, read, write, blockReq, serviceFactorBad, ambientBad, nominalBad, ambientCoefBad} = 8'h00;
		address = 8'h00;
		writedata = 32'h0;
		byteenable = 4'hf;
		thermalCapacity = 12'h000;
		measCurrent = 16'h0000;
		pickupCurrent = 16'h044c;
		serviceFactorSet = 16'h0078;
		ambientFactorSet = 16'h0082;
		nominalFactorSet = 16'h008c;
		fail_count = 0;
		checks_done = 0;
		cycles = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		testDefaults();
		testAlarms();
		testTrip();
		testDelay();
		testBlock();
		testLoad();
		testFaults();
		stop_test();
	end
endmodule // tb_thermal_overload_output_stage

`default_nettype wire
